// ### shared/lcd_ctrl_pkg.sv
// register map, field layout and codes of the lcd control slice
package lcd_ctrl_pkg;

	// ---------------------------------------------------------------
	// register indexes; byte address is four times the index
	// ---------------------------------------------------------------
	localparam logic [29:0] IDX_DISPLAY = 30'h000050A0;
	localparam logic [29:0] IDX_DUTY    = 30'h000050A2;
	localparam logic [29:0] IDX_REG_CTL = 30'h000050A3;
	localparam logic [29:0] IDX_BOOST   = 30'h000050A4;
	localparam logic [29:0] IDX_MASK    = 30'h000050A5;
	localparam logic [29:0] IDX_FLAG    = 30'h000050A6;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int POS_HEAVY_LOAD = 4;
	localparam int POS_SRC_SEL    = 1;
	localparam int POS_BOOST_ON   = 0;
	localparam int POS_FRAME      = 0;

	// ---------------------------------------------------------------
	// codes and reset values
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DUTY_RSV0 = 2'h0,
		DUTY_16   = 2'h1,
		DUTY_32   = 2'h2,
		DUTY_RSV3 = 2'h3
	} duty_t;

	typedef enum logic [1:0] {
		DISP_OFF     = 2'h0,
		DISP_NORMAL  = 2'h1,
		DISP_ALL_ON  = 2'h2,
		DISP_ALL_OFF = 2'h3
	} display_t;

	localparam duty_t    DUTY_RESET    = DUTY_32;
	localparam display_t DISPLAY_RESET = DISP_OFF;
	localparam logic     BIT_RESET     = 1'b0;

	// ---------------------------------------------------------------
	// active electrode counts per duty
	// ---------------------------------------------------------------
	localparam int COM_MAX  = 32;
	localparam int SEG_MAX  = 88;
	localparam int COM_D32  = 32;
	localparam int SEG_D32  = 72;
	localparam int COM_D16  = 16;
	localparam int SEG_D16  = 88;

	localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;
	localparam logic [31:0] WORD_ZERO         = 32'h00000000;

endpackage

// ### rtl/duty_decode.sv
// registered common and segment enable masks from the duty code
module duty_decode
	import lcd_ctrl_pkg::*;
#(
	parameter int NCOM = COM_MAX,
	parameter int NSEG = SEG_MAX
) (
	// clock and reset
	input  wire logic            hclk,
	input  wire logic            hresetn,
	// duty code in
	input  wire duty_t           duty,
	// electrode enables out
	output logic [NCOM-1:0]      com_en,
	output logic [NSEG-1:0]      seg_en
);

	int ncom;
	int nseg;

	always_comb begin
		ncom = 0;
		nseg = 0;
		unique case (duty)
			DUTY_32: begin
				ncom = COM_D32;
				nseg = SEG_D32;
			end
			DUTY_16: begin
				ncom = COM_D16;
				nseg = SEG_D16;
			end
			// reserved codes drive nothing
			DUTY_RSV0, DUTY_RSV3: begin
				ncom = 0;
				nseg = 0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			com_en <= '0;
			seg_en <= '0;
		end else begin
			for (int i = 0; i < NCOM; i++) begin
				com_en[i] <= (i < ncom);
			end
			for (int j = 0; j < NSEG; j++) begin
				seg_en[j] <= (j < nseg);
			end
		end
	end

endmodule

// ### rtl/lcd_ctrl.sv
// lcd driver control slice: duty, regulator, booster, frame interrupt
//
// Overview of operation
// - duty code 2 gives 32 commons/72 segments, 1 gives 16/88, reset 2.
// - regulator control bit 4 turns heavy-load protection on; reset 0.
// - booster control bit 1 picks boosted supply (1) or main supply (0).
// - booster control bit 0 turns the voltage booster on; reset 0.
// - mask bit 0 lets the frame interrupt through when set; reset 0.
// - every rising edge of the frame signal sets the frame flag.
// - interrupt output is high one cycle after flag and enable are both set.
// - writing 1 clears the flag, writing 0 keeps it; reads show pending and clear it.
// - sleep leaves the display field alone; software turns it off first.
// - display field: 0 off, 1 normal, 2 all on, 3 all off; reset 0.
module lcd_ctrl
	import lcd_ctrl_pkg::*;
#(
	parameter int NCOM = COM_MAX,
	parameter int NSEG = SEG_MAX
) (
	// clock and reset
	input  wire logic            hclk,
	input  wire logic            hresetn,
	// ahb-lite slave
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic            hready,
	input  wire logic [31:0]     hwdata,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	// frame timing from the drive sequencer
	input  wire logic            frame_sig,
	// interrupt to the controller
	output logic                 irq,
	// analog and drive controls
	output display_t             display_mode,
	output logic                 drive_voltage_en,
	output logic                 heavy_load_protect,
	output logic                 regulator_source_sel,
	output logic                 booster_on,
	output logic [NCOM-1:0]      com_en,
	output logic [NSEG-1:0]      seg_en
);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	display_t                    display_control_field;
	duty_t                       drive_duty_sel;
	logic                        frame_irq_enable;
	logic                        frame_irq_flag;
	logic                        frame_prev_reg;

	// ---------------------------------------------------------------
	// bus address phase
	// ---------------------------------------------------------------
	logic                        take;
	logic                        wr_pend_reg;
	logic [29:0]                 wr_idx_reg;
	logic                        do_write;
	logic                        rd_flag_now;
	logic [7:0]                  rd_byte;

	// zero wait states: a transfer is taken when hready is seen high
	assign take = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= '0;
		end else begin
			wr_pend_reg <= take && hwrite;
			if (take) begin
				wr_idx_reg <= haddr[31:2];
			end
		end
	end

	// a write lands in its data phase, when hwdata stands
	assign do_write = wr_pend_reg;

	// size is unused: only whole-word transfers reach this slave
	logic                        unused_ok;
	assign unused_ok = &hsize;

	// ---------------------------------------------------------------
	// display control
	// ---------------------------------------------------------------
	// no sleep input: entering sleep never touches this field, so
	// software must switch the display off first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			display_control_field <= DISPLAY_RESET;
		end else if (do_write && wr_idx_reg == IDX_DISPLAY) begin
			// the clock-start ordering is left to software
			display_control_field <= display_t'(hwdata[1:0]);
		end
	end

	// ---------------------------------------------------------------
	// drive duty
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_duty_sel <= DUTY_RESET;
		end else if (do_write && wr_idx_reg == IDX_DUTY) begin
			drive_duty_sel <= duty_t'(hwdata[1:0]);
		end
	end

	duty_decode #(
		.NCOM (NCOM),
		.NSEG (NSEG)
	) u_duty (
		.hclk    (hclk),
		.hresetn (hresetn),
		.duty    (drive_duty_sel),
		.com_en  (com_en),
		.seg_en  (seg_en)
	);

	// ---------------------------------------------------------------
	// regulator and booster
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			heavy_load_protect <= BIT_RESET;
		end else if (do_write && wr_idx_reg == IDX_REG_CTL) begin
			heavy_load_protect <= hwdata[POS_HEAVY_LOAD];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			regulator_source_sel <= BIT_RESET;
			booster_on           <= BIT_RESET;
		end else if (do_write && wr_idx_reg == IDX_BOOST) begin
			regulator_source_sel <= hwdata[POS_SRC_SEL];
			booster_on           <= hwdata[POS_BOOST_ON];
		end
	end

	// ---------------------------------------------------------------
	// frame interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_irq_enable <= BIT_RESET;
		end else if (do_write && wr_idx_reg == IDX_MASK) begin
			frame_irq_enable <= hwdata[POS_FRAME];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_prev_reg <= 1'b0;
		end else begin
			frame_prev_reg <= frame_sig;
		end
	end

	logic                        frame_rise;
	logic                        flag_wclr;

	assign frame_rise = frame_sig && !frame_prev_reg;
	assign flag_wclr  = do_write && wr_idx_reg == IDX_FLAG
		&& hwdata[POS_FRAME];
	// a taken read of the flag register clears it as well
	assign rd_flag_now = take && !hwrite && haddr[31:2] == IDX_FLAG;

	// set beats clear so an edge in the clearing cycle is kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_irq_flag <= BIT_RESET;
		end else if (frame_rise) begin
			frame_irq_flag <= 1'b1;
		end else if (flag_wclr || rd_flag_now) begin
			frame_irq_flag <= 1'b0;
		end
	end

	// follows the flag and enable one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= frame_irq_flag && frame_irq_enable;
		end
	end

	// ---------------------------------------------------------------
	// drive outputs
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			display_mode     <= DISPLAY_RESET;
			drive_voltage_en <= 1'b0;
		end else begin
			display_mode     <= display_control_field;
			// display off stops the regulator feed
			drive_voltage_en <= display_control_field != DISP_OFF;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		unique case (haddr[31:2])
			IDX_DISPLAY: begin
				rd_byte[1:0] = display_control_field;
			end
			IDX_DUTY: begin
				rd_byte[1:0] = drive_duty_sel;
			end
			IDX_REG_CTL: begin
				rd_byte[POS_HEAVY_LOAD] = heavy_load_protect;
			end
			IDX_BOOST: begin
				rd_byte[POS_SRC_SEL]  = regulator_source_sel;
				rd_byte[POS_BOOST_ON] = booster_on;
			end
			IDX_MASK: begin
				rd_byte[POS_FRAME] = frame_irq_enable;
			end
			IDX_FLAG: begin
				rd_byte[POS_FRAME] = frame_irq_flag;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// reserved bits and unmapped words read as zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= WORD_ZERO;
		end else if (take && !hwrite) begin
			hrdata <= {24'h000000, rd_byte};
		end else if (take) begin
			hrdata <= WORD_ZERO;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// are software duties; the set-over-clear flag safe

endmodule

// ### verif/lcd_ctrl_sva.sv
// assertions on the port behaviour of the lcd control slice
module lcd_ctrl_sva
	import lcd_ctrl_pkg::*;
#(
	parameter int NCOM = COM_MAX,
	parameter int NSEG = SEG_MAX
) (
	// clock, reset, bus
	input wire logic            hclk,
	input wire logic            hresetn,
	input wire logic            hsel,
	input wire logic [31:0]     haddr,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic            hready,
	input wire logic [31:0]     hwdata,
	// frame, interrupt, drive
	input wire logic            frame_sig,
	input wire logic            irq,
	input wire display_t        display_mode,
	input wire logic            drive_voltage_en,
	input wire logic            heavy_load_protect,
	input wire logic            regulator_source_sel,
	input wire logic            booster_on,
	input wire logic [NCOM-1:0] com_en,
	input wire logic [NSEG-1:0] seg_en
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [NSEG-1:0] SEG32 = {NSEG{1'b1}} >> (NSEG - SEG_D32);
	logic        wr_q;
	logic [29:0] idx_q;
	logic        mask_m;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------
	// write tracking
	// ----------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q  <= 1'b0;
			idx_q <= 30'h00000000;
		end else begin
			wr_q  <= hsel && htrans[1] && hready && hwrite;
			idx_q <= haddr[31:2];
		end
	end

	// mirror of the enable, so a masked flag is told from a lost one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mask_m <= 1'b0;
		else if (wr_q && idx_q == IDX_MASK)
			mask_m <= hwdata[0];
	end

	sequence s_wr(idx);
		wr_q && idx_q == idx;
	endsequence
	sequence s_frame;
		mask_m && $rose(frame_sig) && !hsel && !wr_q;
	endsequence

	// ----------
	// assertions
	// ----------
	a_duty_full: assert property (
		s_wr(IDX_DUTY) ##0 hwdata[1:0] == 2'h2
		|-> ##2 com_en == '1 && seg_en == SEG32)
		else $error("duty 32 enables wrong");
	a_duty_reserved: assert property (
		s_wr(IDX_DUTY) ##0 hwdata[1] == hwdata[0]
		|-> ##2 com_en == '0 && seg_en == '0)
		else $error("reserved duty drives electrodes");
	a_heavy_load: assert property (
		s_wr(IDX_REG_CTL) |=> heavy_load_protect == $past(hwdata[4]))
		else $error("heavy load bit wrong");
	a_booster_bits: assert property (
		s_wr(IDX_BOOST)
		|=> {regulator_source_sel, booster_on} == $past(hwdata[1:0]))
		else $error("booster bits wrong");
	a_display_code: assert property (
		s_wr(IDX_DISPLAY) |-> ##2 display_mode == $past(hwdata[1:0], 2)
		&& drive_voltage_en == ($past(hwdata[1:0], 2) != 2'h0))
		else $error("display mode wrong");
	a_irq_masked: assert property (
		!mask_m [*2] |-> !irq)
		else $error("masked interrupt raised");
	a_frame_irq: assert property (
		s_frame |-> ##2 irq)
		else $error("frame edge gave no interrupt");
	a_flag_clear: assert property (
		s_wr(IDX_FLAG) ##0 hwdata[0] && !frame_sig |-> ##2 !irq)
		else $error("flag clear left interrupt high");
endmodule

bind lcd_ctrl lcd_ctrl_sva #(.NCOM(NCOM), .NSEG(NSEG)) u_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.frame_sig(frame_sig), .irq(irq), .display_mode(display_mode),
	.drive_voltage_en(drive_voltage_en),
	.heavy_load_protect(heavy_load_protect),
	.regulator_source_sel(regulator_source_sel),
	.booster_on(booster_on), .com_en(com_en), .seg_en(seg_en)
);

// ### verif/lcd_panel_model.sv
// panel model: counts the electrodes that the driver enables
module lcd_panel_model
	import lcd_ctrl_pkg::*;
#(
	parameter int NCOM = COM_MAX,
	parameter int NSEG = SEG_MAX
) (
	// electrode enables from the driver
	input  wire logic [NCOM-1:0] com_en,
	input  wire logic [NSEG-1:0] seg_en,
	// electrodes seen driven
	output logic      [7:0]      com_lit,
	output logic      [7:0]      seg_lit
);
	timeunit 1ns;
	timeprecision 1ns;
	// a panel only sees driven lines, never the duty code itself
	assign com_lit = 8'($countones(com_en));
	assign seg_lit = 8'($countones(seg_en));
endmodule

// ### verif/tb_lcd_ctrl.sv
// self-checking bench for the lcd control slice
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h, expected %h", $time, a, b); end end

module tb_lcd_ctrl
	import lcd_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk, hresetn, hsel, hwrite, frame_sig;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic        hreadyout, hresp, irq, drive_voltage_en;
	logic        heavy_load_protect, regulator_source_sel, booster_on;
	display_t    display_mode;
	logic [31:0] com_en;
	logic [87:0] seg_en;
	logic [7:0]  com_lit, seg_lit;
	int          err_count, checked;
	logic [29:0] idx_tab [7] = '{IDX_DISPLAY, IDX_DUTY, IDX_REG_CTL,
		IDX_BOOST, IDX_MASK, IDX_FLAG, 30'h000050A7};
	logic [31:0] rst_tab [7] = '{0, 32'h2, 0, 0, 0, 0, 0};
	logic [31:0] one_tab [7] = '{32'h3, 32'h3, 32'h10, 32'h3, 32'h1, 0, 0};
	logic [7:0]  com_tab [4] = '{8'h00, 8'h10, 8'h20, 8'h00};
	logic [7:0]  seg_tab [4] = '{8'h00, 8'h58, 8'h48, 8'h00};

	lcd_ctrl u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .frame_sig(frame_sig),
		.irq(irq), .display_mode(display_mode),
		.drive_voltage_en(drive_voltage_en),
		.heavy_load_protect(heavy_load_protect),
		.regulator_source_sel(regulator_source_sel),
		.booster_on(booster_on), .com_en(com_en), .seg_en(seg_en)
	);
	lcd_panel_model u_panel (
		.com_en(com_en), .seg_en(seg_en),
		.com_lit(com_lit), .seg_lit(seg_lit)
	);

	// ----------
	// bus and stimulus tasks
	// ----------
	task automatic bus(input logic w, input logic [29:0] idx,
		input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ_BIT;
		haddr  <= {idx, 2'b00};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic pulse();
		frame_sig <= 1'b1;
		repeat (2) @(posedge hclk);
		frame_sig <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		#(100 * 1000);
		err_count++;
		conclude();
	end

	// ----------
	// tests
	// ----------
	initial begin
		{hresetn, hsel, hwrite, frame_sig, htrans} = '0;
		{haddr, hwdata, err_count, checked} = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		// enables are launched at the first edge after release
		repeat (2) @(posedge hclk);
		`CHK(com_lit, 8'h20)
		`CHK(seg_lit, 8'h48)
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, idx_tab[i], WORD_ZERO);
			`CHK(rd, rst_tab[i])
			`CHK(hresp, 1'b0)
		end
		for (int i = 0; i < 7; i++)
			bus(1'b1, idx_tab[i], 32'hFFFFFFFF);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, idx_tab[i], WORD_ZERO);
			`CHK(rd, one_tab[i])
		end
		`CHK({heavy_load_protect, regulator_source_sel, booster_on}, 3'h7)
		bus(1'b1, IDX_REG_CTL, WORD_ZERO);
		bus(1'b1, IDX_BOOST, WORD_ZERO);
		for (int d = 0; d < 4; d++) begin
			bus(1'b1, IDX_DUTY, 32'(d));
			repeat (2) @(posedge hclk);
			`CHK(com_lit, com_tab[d])
			`CHK(seg_lit, seg_tab[d])
		end
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, IDX_DISPLAY, 32'(m));
			repeat (2) @(posedge hclk);
			`CHK(display_mode, display_t'(m))
			`CHK(drive_voltage_en, m != 0)
		end
		bus(1'b1, IDX_DISPLAY, WORD_ZERO);
		bus(1'b1, IDX_MASK, WORD_ZERO);
		pulse();
		`CHK(irq, 1'b0)
		bus(1'b0, IDX_FLAG, WORD_ZERO);
		`CHK(rd, 32'h00000001)
		bus(1'b1, IDX_FLAG, 32'h00000001);
		bus(1'b1, IDX_MASK, 32'h00000001);
		pulse();
		`CHK(irq, 1'b1)
		bus(1'b1, IDX_FLAG, WORD_ZERO);
		@(posedge hclk);
		`CHK(irq, 1'b1)
		bus(1'b1, IDX_FLAG, 32'h00000001);
		repeat (2) @(posedge hclk);
		`CHK(irq, 1'b0)
		conclude();
	end
endmodule
